//--- hdl/fan_pwm_drive_channel.sv
// Three-channel fan drive: registers, spin-up and PWM outputs
//
// Functional notes
// - 2-wire fan sensing only works in low frequency mode.
// - Analog config bits 2..0 switch each fan input to 2-wire sensing.
// - Sense config bits 3:2 pick threshold 20, 40, 80 or 130 mV.
// - Spin-up drives full duty until two fan pulses, then running duty.
// - Missing two pulses within the timeout window raises a fail event.
// - Config bits 2:0 pick timeout: none or 100 ms to 4 s, default 250 ms.
// - Spin-up disable bit replaces pulse spin-up with a fixed-time spin.
// - Config bit 4 selects output polarity for full duty.
// - Rate bits 2:0 pick low frequency 11.0 to 88.2 Hz, default 35.3 Hz.
// - High frequency mode uses a fixed 22.5 kHz, ignoring rate select.
// - Automatic mode follows the temperature loop duty without software.
// - Config bits 7:5 pick control source; 111 is manual.
// - In manual mode a duty register write sets the output duty.
// - Duty registers are 8 bits, about 0.39 percent per step.
// - Reading duty returns the duty actually driven.
`timescale 1ns/1ps
`include "fan_drive_consts.svh"
module fan_pwm_drive_channel #(
   parameter int CLK_HZ = `CLK_HZ
) (
   // Clock and reset
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   // Register port
   input  wire fan_drive_pkg::reg_byte_t    reg_addr_i,
   input  wire logic                        reg_wr_en_i,
   input  wire logic                        reg_rd_en_i,
   input  wire fan_drive_pkg::reg_byte_t    reg_wdata_i,
   output fan_drive_pkg::reg_byte_t         reg_rdata_o,
   // Mode bits and automatic duty held elsewhere in the device
   input  wire logic                        high_low_rate_sel_mode_i,
   input  wire logic                        pulse_spinup_disable_i,
   input  wire fan_drive_pkg::duty_t [2:0]  auto_duty_i,
   // Fan side
   input  wire logic [2:0]                  fan_pulse_input_i,
   input  wire logic [2:0]                  sense_cmp_i,
   output logic [2:0]                       pwm_o,
   output logic [3:0]                       analog_sense_enable_o,
   output logic [1:0]                       sense_threshold_sel_o,
   // Events
   output logic [2:0]                       spinup_fail_o
);
   import fan_drive_pkg::*;

   // Clock must give at least one cycle per millisecond
   if (CLK_HZ < 1000) begin : g_clk_check
      $error("CLK_HZ too low for millisecond timing");
   end

   // Clock cycles per duty step for a rate code
   function automatic step_len_t rate_step(input logic [2:0] code,
                                           input logic       hf);
      int r10;
      int s;
      case (code)
         3'h0:    r10 = `LF_RATE0_HZ10;
         3'h1:    r10 = `LF_RATE1_HZ10;
         3'h2:    r10 = `LF_RATE2_HZ10;
         3'h3:    r10 = `LF_RATE3_HZ10;
         3'h4:    r10 = `LF_RATE4_HZ10;
         3'h5:    r10 = `LF_RATE5_HZ10;
         3'h6:    r10 = `LF_RATE6_HZ10;
         default: r10 = `LF_RATE7_HZ10;
      endcase
      if (hf) begin
         r10 = `HF_RATE_HZ10;
      end
      s = (CLK_HZ * 10) / (r10 * `DUTY_STEPS);
      if (s < 1) begin
         s = 1;
      end
      return s[23:0];
   endfunction

   // Clock cycles of the start-up window for a timeout code
   function automatic tmo_len_t tmo_cycles(input logic [2:0] code);
      int ms;
      case (code)
         3'h0:    ms = 0;
         3'h1:    ms = `TMO1_MS;
         3'h2:    ms = `TMO2_MS;
         3'h3:    ms = `TMO3_MS;
         3'h4:    ms = `TMO4_MS;
         3'h5:    ms = `TMO5_MS;
         3'h6:    ms = `TMO6_MS;
         default: ms = `TMO7_MS;
      endcase
      return tmo_len_t'((CLK_HZ / 1000) * ms);
   endfunction

   // Register storage
   duty_t     duty_q [3];
   duty_t     duty_d [3];
   reg_byte_t cfg_q [3];
   reg_byte_t cfg_d [3];
   reg_byte_t rate_q [3];
   reg_byte_t rate_d [3];
   reg_byte_t analog_q, analog_d;
   reg_byte_t sense_q, sense_d;
   reg_byte_t rdata_q, rdata_d;

   // Per-channel status
   logic [2:0] spinning;
   logic [2:0] fail;
   logic [2:0] manual;
   logic [2:0] wave;
   duty_t      driven [3];

   // Fan input synchronisers and edge detect
   logic [2:0] fan_pulse_input_s1_q, fan_pulse_input_s2_q;
   logic [2:0] cmp_s1_q, cmp_s2_q;
   logic [2:0] sel_q, sel_d;
   logic [2:0] pulse;
   logic [3:0] ain_eff;

   // Registered outputs
   logic [2:0] pwm_q, pwm_d;
   logic [3:0] ain_q;
   logic [1:0] thr_q;

   // Analog sensing allowed only in low frequency mode
   assign ain_eff = analog_q[3:0] & {4{~high_low_rate_sel_mode_i}};

   // Pulse source per channel, edge against previous sample
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sel_d[i] = ain_eff[i] ? cmp_s2_q[i] : fan_pulse_input_s2_q[i];
      end
      pulse = sel_d & ~sel_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fan_pulse_input_s1_q <= 3'h7;                 // Pulled-up pins idle high
         fan_pulse_input_s2_q <= 3'h7;
         cmp_s1_q  <= 3'h0;
         cmp_s2_q  <= 3'h0;
         sel_q     <= 3'h7;                 // No false edge after reset
      end else begin
         fan_pulse_input_s1_q <= fan_pulse_input_i;
         fan_pulse_input_s2_q <= fan_pulse_input_s1_q;
         cmp_s1_q  <= sense_cmp_i;
         cmp_s2_q  <= cmp_s1_q;
         sel_q     <= sel_d;
      end
   end

   // Register writes and automatic duty tracking
   always_comb begin
      analog_d = analog_q;
      sense_d  = sense_q;
      for (int i = 0; i < 3; i++) begin
         cfg_d[i]  = cfg_q[i];
         rate_d[i] = rate_q[i];
         manual[i] = (cfg_q[i][`SRC_LSB +: 3] == `SRC_MANUAL);
         if (manual[i]) begin
            duty_d[i] = duty_q[i];
         end else begin
            duty_d[i] = auto_duty_i[i];
         end
      end
      if (reg_wr_en_i) begin
         case (reg_addr_i)
            `DUTY1_OFS: if (manual[0]) duty_d[0] = reg_wdata_i;
            `DUTY2_OFS: if (manual[1]) duty_d[1] = reg_wdata_i;
            `DUTY3_OFS: if (manual[2]) duty_d[2] = reg_wdata_i;
            `CFG1_OFS:       cfg_d[0]  = reg_wdata_i;
            `CFG2_OFS:       cfg_d[1]  = reg_wdata_i;
            `CFG3_OFS:       cfg_d[2]  = reg_wdata_i;
            `RATE1_OFS:      rate_d[0] = reg_wdata_i;
            `RATE2_OFS:      rate_d[1] = reg_wdata_i;
            `RATE3_OFS:      rate_d[2] = reg_wdata_i;
            `ANALOG_CFG_OFS: analog_d  = reg_wdata_i;
            `SENSE_CFG_OFS:  sense_d   = reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Duty actually driven: full during spin-up
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         driven[i] = spinning[i] ? 8'hFF : duty_q[i];
      end
   end

   // Read data, latched on a read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_en_i) begin
         case (reg_addr_i)
            `DUTY1_OFS:      rdata_d = driven[0];
            `DUTY2_OFS:      rdata_d = driven[1];
            `DUTY3_OFS:      rdata_d = driven[2];
            `CFG1_OFS:       rdata_d = cfg_q[0];
            `CFG2_OFS:       rdata_d = cfg_q[1];
            `CFG3_OFS:       rdata_d = cfg_q[2];
            `RATE1_OFS:      rdata_d = rate_q[0];
            `RATE2_OFS:      rdata_d = rate_q[1];
            `RATE3_OFS:      rdata_d = rate_q[2];
            `ANALOG_CFG_OFS: rdata_d = analog_q;
            `SENSE_CFG_OFS:  rdata_d = sense_q;
            default:         rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= `DUTY_RST;
            cfg_q[i]  <= `CFG_RST;
            rate_q[i] <= `RATE_RST;
         end
         analog_q <= `ANALOG_RST;
         sense_q  <= `SENSE_RST;
         rdata_q  <= 8'h00;
      end else begin
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= duty_d[i];
            cfg_q[i]  <= cfg_d[i];
            rate_q[i] <= rate_d[i];
         end
         analog_q <= analog_d;
         sense_q  <= sense_d;
         rdata_q  <= rdata_d;
      end
   end

   // Channel instances
   for (genvar c = 0; c < 3; c++) begin : g_chan
      drive_if drv ();

      // Waveform settings from registers
      assign drv.duty     = driven[c];
      assign drv.step_len = rate_step(rate_q[c][`RATE_LSB +: 3],
                                      high_low_rate_sel_mode_i);
      assign drv.invert   = cfg_q[c][`POL_BIT];
      assign wave[c]      = drv.wave;

      pwm_wave_gen u_gen (
         .core_clk_i (core_clk_i),
         .rst_n_i    (rst_n_i),
         .drv        (drv)
      );

      spinup_timer u_spin (
         .core_clk_i (core_clk_i),
         .rst_n_i    (rst_n_i),
         .run_i      (duty_q[c] != 8'h00),
         .pulse_i    (pulse[c]),
         .fixed_i    (pulse_spinup_disable_i),
         .limit_i    (tmo_cycles(cfg_q[c][`TMO_LSB +: 3])),
         .spinning_o (spinning[c]),
         .fail_o     (fail[c])
      );
   end

   // Output staging
   assign pwm_d = wave;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_q <= 3'h0;
         ain_q <= 4'h0;
         thr_q <= 2'h0;
      end else begin
         pwm_q <= pwm_d;
         ain_q <= ain_eff;
         thr_q <= sense_q[`THR_LSB +: 2];
      end
   end

   assign pwm_o                 = pwm_q;
   assign analog_sense_enable_o = ain_q;
   assign sense_threshold_sel_o = thr_q;
   assign spinup_fail_o         = fail;
   assign reg_rdata_o           = rdata_q;
endmodule

//--- hdl/fan_drive_consts.svh
// Register offsets, field positions, reset values and timing figures
`ifndef FAN_DRIVE_CONSTS_SVH
`define FAN_DRIVE_CONSTS_SVH

// Register offsets
`define DUTY1_OFS       8'h30
`define DUTY2_OFS       8'h31
`define DUTY3_OFS       8'h32
`define CFG1_OFS        8'h5C
`define CFG2_OFS        8'h5D
`define CFG3_OFS        8'h5E
`define RATE1_OFS       8'h5F
`define RATE2_OFS       8'h60
`define RATE3_OFS       8'h61
`define ANALOG_CFG_OFS  8'h73
`define SENSE_CFG_OFS   8'h7D

// Field positions
`define TMO_LSB         0
`define POL_BIT         4
`define SRC_LSB         5
`define SRC_MANUAL      3'h7
`define RATE_LSB        0
`define THR_LSB         2

// Reset values
`define DUTY_RST        8'h00
`define CFG_RST         8'h02
`define RATE_RST        8'h04
`define ANALOG_RST      8'h00
`define SENSE_RST       8'h00

// Timing: clock in Hz, rates in tenths of Hz, timeouts in ms
`define CLK_HZ          25000000
`define DUTY_STEPS      256
`define HF_RATE_HZ10    225000
`define LF_RATE0_HZ10   110
`define LF_RATE1_HZ10   147
`define LF_RATE2_HZ10   221
`define LF_RATE3_HZ10   294
`define LF_RATE4_HZ10   353
`define LF_RATE5_HZ10   441
`define LF_RATE6_HZ10   588
`define LF_RATE7_HZ10   882
`define TMO1_MS         100
`define TMO2_MS         250
`define TMO3_MS         400
`define TMO4_MS         667
`define TMO5_MS         1000
`define TMO6_MS         2000
`define TMO7_MS         4000

`endif

//--- hdl/fan_drive_pkg.sv
// Types shared by the fan drive modules
package fan_drive_pkg;
   typedef logic [7:0]  duty_t;
   typedef logic [7:0]  reg_byte_t;
   typedef logic [23:0] step_len_t;
   typedef logic [31:0] tmo_len_t;
   typedef enum logic [1:0] {SPIN_IDLE, SPIN_PULSE, SPIN_FIXED} spin_state_t;
endpackage

//--- hdl/drive_if.sv
// Link between channel control and its waveform generator
`timescale 1ns/1ps
interface drive_if;
   import fan_drive_pkg::*;
   duty_t     duty;
   step_len_t step_len;
   logic      invert;
   logic      wave;
   modport ctrl (output duty, step_len, invert, input wave);
   modport gen  (input duty, step_len, invert, output wave);
endinterface

//--- hdl/pwm_wave_gen.sv
// One channel pulse width waveform generator
`timescale 1ns/1ps
module pwm_wave_gen (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // Drive settings and waveform
   drive_if.gen      drv
);
   import fan_drive_pkg::*;

   step_len_t pre_q, pre_d;
   logic [7:0] pos_q, pos_d;
   duty_t     duty_q, duty_d;
   logic      inv_q, inv_d;
   logic      wave_q, wave_d;
   logic      active;

   // Step divider, period position and period-start latching
   always_comb begin
      pre_d  = pre_q;
      pos_d  = pos_q;
      duty_d = duty_q;
      inv_d  = inv_q;
      if (pre_q >= drv.step_len - step_len_t'(1)) begin
         pre_d = '0;
         pos_d = pos_q + 8'h01;
         if (pos_q == 8'hFF) begin
            duty_d = drv.duty;
            inv_d  = drv.invert;
         end
      end else begin
         pre_d = pre_q + step_len_t'(1);
      end
      // Zero never active, full code always active
      active = (duty_q == 8'hFF) || (pos_q < duty_q);
      wave_d = active ^ inv_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_q  <= '0;
         pos_q  <= 8'h00;
         duty_q <= 8'h00;
         inv_q  <= 1'b0;
         wave_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         pos_q  <= pos_d;
         duty_q <= duty_d;
         inv_q  <= inv_d;
         wave_q <= wave_d;
      end
   end

   assign drv.wave = wave_q;
endmodule

//--- hdl/spinup_timer.sv
// Fan start-up sequencer: pulse-counted or fixed-time spin-up
`timescale 1ns/1ps
module spinup_timer (
   // Clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_n_i,
   // Control
   input  wire logic                   run_i,
   input  wire logic                   pulse_i,
   input  wire logic                   fixed_i,
   input  wire fan_drive_pkg::tmo_len_t limit_i,
   // Status
   output logic                        spinning_o,
   output logic                        fail_o
);
   import fan_drive_pkg::*;

   spin_state_t state_q, state_d;
   tmo_len_t    cnt_q, cnt_d;
   logic        seen_q, seen_d;
   logic        run_q, run_d;
   logic        fail_q, fail_d;

   // Next state of the spin-up sequence
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + tmo_len_t'(1);
      seen_d  = seen_q;
      run_d   = run_i;
      fail_d  = 1'b0;
      case (state_q)
         SPIN_IDLE: begin
            cnt_d  = '0;
            seen_d = 1'b0;
            if (run_i && !run_q) begin
               if (!fixed_i) begin
                  state_d = SPIN_PULSE;
               end else if (limit_i != '0) begin
                  state_d = SPIN_FIXED;
               end
            end
         end
         SPIN_PULSE: begin
            if (pulse_i && seen_q) begin
               state_d = SPIN_IDLE;
            end else if (limit_i != '0 &&
                         cnt_q >= limit_i - tmo_len_t'(1)) begin
               state_d = SPIN_IDLE;
               fail_d  = 1'b1;
            end else if (pulse_i) begin
               seen_d = 1'b1;
            end
         end
         SPIN_FIXED: begin
            if (cnt_q >= limit_i - tmo_len_t'(1)) begin
               state_d = SPIN_IDLE;
            end
         end
         default: state_d = SPIN_IDLE;
      endcase
      if (!run_i) begin
         state_d = SPIN_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= SPIN_IDLE;
         cnt_q   <= '0;
         seen_q  <= 1'b0;
         run_q   <= 1'b0;
         fail_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         seen_q  <= seen_d;
         run_q   <= run_d;
         fail_q  <= fail_d;
      end
   end

   assign spinning_o = (state_q != SPIN_IDLE);
   assign fail_o     = fail_q;
endmodule

//--- tb/fan_model.sv
// Behavioural fans: fan_pulse_input or 2-wire sense pulses while spinning
`timescale 1ns/1ps
module fan_model #(
   parameter int GAP = 10
) (
   // Clock
   input  wire logic       core_clk_i,
   // Per-fan behaviour set by the bench
   input  wire logic [2:0] spin_i,
   input  wire logic [2:0] two_wire_i,
   // Fan pins
   output logic [2:0]      fan_pulse_input_o,
   output logic [2:0]      sense_o
);
   int   cnt = 0;
   logic beat;
   // Pulse beat: two cycles out of every GAP
   always @(negedge core_clk_i) cnt <= (cnt + 1) % GAP;
   assign beat = (cnt < 2);
   // Pulled-up fan_pulse_input idles high, comparator idles low
   assign fan_pulse_input_o  = ~(spin_i & ~two_wire_i & {3{beat}});
   assign sense_o = spin_i & two_wire_i & {3{beat}};
endmodule

//--- tb/fan_drive_properties.sv
// Concurrent checks on the fan drive ports
`timescale 1ns/1ps
module fan_drive_properties (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   // Register port
   input  wire fan_drive_pkg::reg_byte_t reg_addr_i,
   input  wire logic                     reg_wr_en_i,
   input  wire logic                     reg_rd_en_i,
   input  wire fan_drive_pkg::reg_byte_t reg_wdata_i,
   input  wire fan_drive_pkg::reg_byte_t reg_rdata_o,
   // Modes and fan side
   input  wire logic                     high_low_rate_sel_mode_i,
   input  wire logic                     pulse_spinup_disable_i,
   input  wire logic [2:0]               pwm_o,
   input  wire logic [3:0]               analog_sense_enable_o,
   input  wire logic [1:0]               sense_threshold_sel_o,
   input  wire logic [2:0]               spinup_fail_o
);
   import fan_drive_pkg::*;
   logic thr_wr;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Write aimed at the threshold register
   assign thr_wr = reg_wr_en_i && (reg_addr_i == 8'h7D);
   thr_follow_a: assert property (
      thr_wr ##1 !thr_wr |=>
      sense_threshold_sel_o == $past(reg_wdata_i[3:2], 2))
      else $error("threshold output differs from written field");
   thr_hold_a: assert property (
      !thr_wr [*2] |=> $stable(sense_threshold_sel_o))
      else $error("threshold output moved without a write");
   analog_hf_a: assert property (
      high_low_rate_sel_mode_i [*2] |=> analog_sense_enable_o == 4'h0)
      else $error("analog sensing enabled in high rate mode");
   fail_pulse_a: assert property (
      spinup_fail_o != 3'b000 |=>
      (spinup_fail_o & $past(spinup_fail_o)) == 3'b000)
      else $error("start-up fail event longer than one cycle");
   fixed_nofail_a: assert property (
      pulse_spinup_disable_i [*8] |-> spinup_fail_o == 3'b000)
      else $error("fail event during fixed-time spin-up");
   rdata_hold_a: assert property (
      !reg_rd_en_i |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");
   reset_quiet_a: assert property (
      $rose(rst_n_i) |-> pwm_o == 3'b000 && spinup_fail_o == 3'b000)
      else $error("outputs active right after reset");
   reset_sense_a: assert property (
      $rose(rst_n_i) |->
      analog_sense_enable_o == 4'h0 && sense_threshold_sel_o == 2'b00)
      else $error("sense outputs not cleared by reset");
endmodule

bind fan_pwm_drive_channel fan_drive_properties fan_drive_properties_i (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wr_en_i(reg_wr_en_i), .reg_rd_en_i(reg_rd_en_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .high_low_rate_sel_mode_i(high_low_rate_sel_mode_i),
   .pulse_spinup_disable_i(pulse_spinup_disable_i), .pwm_o(pwm_o),
   .analog_sense_enable_o(analog_sense_enable_o),
   .sense_threshold_sel_o(sense_threshold_sel_o),
   .spinup_fail_o(spinup_fail_o));

//--- tb/tb_top.sv
// Self-checking bench for the three-channel fan drive
`timescale 1ns/1ps
module tb_top;
   import fan_drive_pkg::*;
   logic      clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic      hf = 1'b0, dis = 1'b1;
   reg_byte_t addr = 8'h00, wdata = 8'h00, rdata;
   duty_t [2:0] auto_duty = '0;
   logic [2:0] fan_pulse_input, sense, pwm, fail, spin = '0, two_wire = '0;
   logic [3:0] ana;
   logic [1:0] thr;
   int        err_total = 0, cmp_count = 0, fails [3] = '{0, 0, 0};
   // Clock, 40 ns period
   always #20 clk = ~clk;
   // Small clock figure: short timeouts, low rate codes 0 and 1 still differ
   fan_pwm_drive_channel #(.CLK_HZ(10000)) fan_pwm_drive_channel_i (
      .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wr_en_i(wr_en), .reg_rd_en_i(rd_en), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .high_low_rate_sel_mode_i(hf),
      .pulse_spinup_disable_i(dis), .auto_duty_i(auto_duty),
      .fan_pulse_input_i(fan_pulse_input), .sense_cmp_i(sense[2:0]), .pwm_o(pwm),
      .analog_sense_enable_o(ana), .sense_threshold_sel_o(thr),
      .spinup_fail_o(fail));
   fan_model fan_model_i (.core_clk_i(clk), .spin_i(spin),
      .two_wire_i(two_wire), .fan_pulse_input_o(fan_pulse_input), .sense_o(sense));
   // Count start-up fail events per channel
   always @(negedge clk) begin
      for (int i = 0; i < 3; i++) if (fail[i] === 1'b1) fails[i]++;
   end
   task automatic results();
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(string name, logic [8:0] exp, logic [8:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(reg_byte_t a, reg_byte_t d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(reg_byte_t a, output reg_byte_t d);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // High cycles of one output over one whole 256-step period
   task automatic hi_count(int ch, output int n);
      repeat (512) @(negedge clk);
      n = 0;
      repeat (256) @(negedge clk) if (pwm[ch] === 1'b1) n++;
   endtask
   // Rising edges of one output over a 1536-cycle window
   task automatic edge_count(int ch, output int n);
      logic prev;
      repeat (800) @(negedge clk);
      prev = pwm[ch];
      n = 0;
      repeat (1536) @(negedge clk) begin
         if (pwm[ch] === 1'b1 && prev === 1'b0) n++;
         prev = pwm[ch];
      end
   endtask
   task automatic s_reset();
      reg_byte_t d;
      reg_byte_t a [13] = '{8'h30, 8'h31, 8'h32, 8'h5C, 8'h5D, 8'h5E,
         8'h5F, 8'h60, 8'h61, 8'h73, 8'h7D, 8'h00, 8'hFF};
      reg_byte_t e [13] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02,
         8'h04, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 13; i++) begin
         rd(a[i], d);
         check("reset value", e[i], d);
      end
      wr(8'h5F, 8'h07);
      rd(8'h5F, d);
      check("rate select", 8'h07, d);
      wr(8'hFF, 8'h55);
      rd(8'hFF, d);
      check("unmapped read", 8'h00, d);
   endtask
   task automatic s_sense();
      wr(8'h73, 8'h0F);
      for (int t = 0; t < 4; t++) begin
         wr(8'h7D, 8'(t << 2));
         repeat (2) @(negedge clk);
         check("threshold", 9'(t), thr);
      end
      check("analog enables", 4'hF, ana);
      hf = 1'b1;
      repeat (3) @(negedge clk);
      check("analog in high rate", 4'h0, ana);
      hf = 1'b0;
   endtask
   task automatic s_manual();
      reg_byte_t d;
      int        n;
      wr(8'h5C, 8'hE0);
      wr(8'h30, 8'h40);
      rd(8'h30, d);
      check("duty1 readback", 8'h40, d);
      hi_count(0, n);
      check("duty1 high", 9'd64, 9'(n));
      wr(8'h5C, 8'hF0);
      hi_count(0, n);
      check("duty1 inverted", 9'd192, 9'(n));
      wr(8'h30, 8'hFF);
      hi_count(0, n);
      check("full inverted", 9'd0, 9'(n));
      wr(8'h5C, 8'hE0);
      hi_count(0, n);
      check("full duty", 9'd256, 9'(n));
      wr(8'h30, 8'h00);
      hi_count(0, n);
      check("zero duty", 9'd0, 9'(n));
   endtask
   task automatic s_auto();
      reg_byte_t d;
      int        n;
      wr(8'h5D, 8'h00);
      auto_duty[1] = 8'h33;
      rd(8'h31, d);
      check("auto duty read", 8'h33, d);
      wr(8'h31, 8'h99);
      rd(8'h31, d);
      check("duty write refused", 8'h33, d);
      hi_count(1, n);
      check("auto duty high", 9'd51, 9'(n));
   endtask
   task automatic s_spin();
      reg_byte_t d;
      dis = 1'b0;
      wr(8'h73, 8'h04);
      two_wire = 3'b100;
      spin = 3'b100;
      wr(8'h5E, 8'hE1);
      wr(8'h32, 8'h40);
      rd(8'h32, d);
      check("spin full duty", 8'hFF, d);
      repeat (40) @(negedge clk);
      rd(8'h32, d);
      check("running duty", 8'h40, d);
      check("no fail", 9'd0, 9'(fails[2]));
      wr(8'h32, 8'h00);
      hf = 1'b1;
      wr(8'h32, 8'h40);
      // Code 1 window is 1000 cycles at this clock figure
      repeat (800) @(negedge clk);
      check("fail too early", 9'd0, 9'(fails[2]));
      repeat (300) @(negedge clk);
      check("fail after timeout", 9'd1, 9'(fails[2]));
      spin = 3'b000;
      two_wire = 3'b000;
      hf = 1'b0;
      dis = 1'b1;
   endtask
   task automatic s_fixed();
      reg_byte_t d;
      wr(8'h5C, 8'hE1);
      wr(8'h30, 8'h40);
      repeat (800) @(negedge clk);
      rd(8'h30, d);
      check("fixed spin", 8'hFF, d);
      repeat (300) @(negedge clk);
      rd(8'h30, d);
      check("after fixed spin", 8'h40, d);
      check("fixed no fail", 9'd0, 9'(fails[0]));
   endtask
   // Rate code 0 gives 3 cycles a step, high rate clamps to 1
   task automatic s_rate();
      int n;
      wr(8'h5F, 8'h00);
      edge_count(0, n);
      check("low rate periods", 9'd2, 9'(n));
      hf = 1'b1;
      edge_count(0, n);
      check("high rate periods", 9'd6, 9'(n));
      hf = 1'b0;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      s_reset();
      s_sense();
      s_manual();
      s_auto();
      s_spin();
      s_fixed();
      s_rate();
      results();
   end
   // Watchdog against a hang
   initial begin
      repeat (30000) @(negedge clk);
      err_total++;
      $display("mismatch run length expected end seen timeout");
      results();
   end
endmodule
